// ==== rtl/tfs_splitter.sv ====
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/100ps
module tfs_splitter #(
  parameter int FLOOR_SIZE = tfs_pkg::FLOOR_DEF,
  parameter int CEILING_SIZE = tfs_pkg::CEIL_DEF,
  parameter int BEAT_LG = tfs_pkg::BEAT_LG_DEF,
  parameter int ADDR_W = 32,
  parameter int SRC_W = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // client a channel
  input wire logic ca_valid,
  output logic ca_ready,
  input wire logic [2:0] ca_opcode,
  input wire logic [2:0] ca_param,
  input wire logic [tfs_pkg::SIZE_W-1:0] ca_size,
  input wire logic [SRC_W-1:0] ca_source,
  input wire logic [ADDR_W-1:0] ca_address,
  input wire logic [(8<<BEAT_LG)/8-1:0] ca_mask,
  input wire logic [(8<<BEAT_LG)-1:0] ca_data,
  // manager a channel
  output logic ma_valid,
  input wire logic ma_ready,
  output logic [2:0] ma_opcode,
  output logic [2:0] ma_param,
  output logic [tfs_pkg::SIZE_W-1:0] ma_size,
  output logic [SRC_W-1:0] ma_source,
  output logic [ADDR_W-1:0] ma_address,
  output logic [(8<<BEAT_LG)/8-1:0] ma_mask,
  output logic [(8<<BEAT_LG)-1:0] ma_data,
  // manager d channel
  input wire logic md_valid,
  output logic md_ready,
  input wire logic [2:0] md_opcode,
  input wire logic [1:0] md_param,
  input wire logic md_denied,
  input wire logic md_corrupt,
  input wire logic [(8<<BEAT_LG)-1:0] md_data,
  // client d channel
  output logic cd_valid,
  input wire logic cd_ready,
  output logic [2:0] cd_opcode,
  output logic [1:0] cd_param,
  output logic [tfs_pkg::SIZE_W-1:0] cd_size,
  output logic [SRC_W-1:0] cd_source,
  output logic cd_denied,
  output logic cd_corrupt,
  output logic [(8<<BEAT_LG)-1:0] cd_data
);
  localparam int DW = 8 << BEAT_LG;
  localparam int MW = DW / 8;
  localparam int SW = tfs_pkg::SIZE_W;
  localparam int CW = tfs_pkg::CNT_W;
  localparam int AW_PK = 6 + SW + SRC_W + ADDR_W + MW + DW;
  localparam int DW_PK = 7 + SW + SRC_W + DW;
  localparam logic [SW-1:0] FLOOR_SZ = SW'(FLOOR_SIZE);
  localparam logic [SW-1:0] CEIL_SZ = SW'(CEILING_SIZE);
  localparam logic [SW-1:0] BLG = SW'(BEAT_LG);

  if (FLOOR_SIZE > CEILING_SIZE || CEILING_SIZE - FLOOR_SIZE >= CW ||
      CEILING_SIZE >= (1 << SW) || BEAT_LG > 7) begin : g_bad
    $error("tfs_splitter: unsupported size parameters");
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [CW-1:0] beats(input logic [SW-1:0] s);
    beats = (s > BLG) ? (CW'(1) << (s - BLG)) : CW'(1);
  endfunction
  function automatic logic has_data(input logic [2:0] op);
    has_data = (op == tfs_pkg::OP_PUTFULL) || (op == tfs_pkg::OP_PUTPART) ||
               (op == tfs_pkg::OP_ARITH) || (op == tfs_pkg::OP_LOGIC);
  endfunction

  // ****************************************
  // apb registers
  // ****************************************
  logic ff_reg;
  logic [1:0] ack_reg;
  logic merge_reg;
  logic [3:0] max_reg;
  logic over_reg;
  logic [CW-1:0] pcnt_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic busy;
  wire apb_acc = psel & penable & ~pready_reg;
  wire apb_wr = psel & penable & pready_reg & pwrite;
  wire sel_ctrl = paddr == tfs_pkg::OFS_CTRL;
  wire sel_stat = paddr == tfs_pkg::OFS_STAT;
  wire sel_pcnt = paddr == tfs_pkg::OFS_PCNT;
  wire sel_none = ~sel_ctrl & ~sel_stat & ~sel_pcnt;
  wire [31:0] ctrl_rd = {24'h0, max_reg, merge_reg, ack_reg, ff_reg};
  wire [31:0] rd_mux;
  assign rd_mux = sel_ctrl ? ctrl_rd :
                  sel_stat ? {30'h0, over_reg, busy} :
                  sel_pcnt ? {{(32-CW){1'b0}}, pcnt_reg} : 32'h0;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= apb_acc;
      prdata_reg <= apb_acc ? rd_mux : 32'h0;
      pslverr_reg <= apb_acc & sel_none;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff_reg <= 1'b0;
      ack_reg <= tfs_pkg::ACK_RST;
      merge_reg <= 1'b0;
      max_reg <= tfs_pkg::MAX_RST;
    end else if (apb_wr && sel_ctrl) begin
      ff_reg <= pwdata[tfs_pkg::CTRL_FF];
      ack_reg <= pwdata[tfs_pkg::CTRL_ACK +: 2];
      merge_reg <= pwdata[tfs_pkg::CTRL_MERGE];
      max_reg <= pwdata[tfs_pkg::CTRL_MAX +: 4];
    end
  end

  // ****************************************
  // client beat holding stage
  // ****************************************
  logic h_v_reg;
  logic h_v_next;
  logic a_rdy_reg;
  logic [2:0] h_op_reg;
  logic [2:0] h_par_reg;
  logic [SW-1:0] h_sz_reg;
  logic [SRC_W-1:0] h_src_reg;
  logic [ADDR_W-1:0] h_adr_reg;
  logic [MW-1:0] h_msk_reg;
  logic [DW-1:0] h_dat_reg;
  logic h_take;
  wire a_fire = ca_valid & a_rdy_reg;
  // one beat in flight keeps ca_ready a plain flop at half throughput
  assign h_v_next = a_fire | (h_v_reg & ~h_take);
  assign ca_ready = a_rdy_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_v_reg <= 1'b0;
      a_rdy_reg <= 1'b0;
    end else begin
      h_v_reg <= h_v_next;
      a_rdy_reg <= ~h_v_next;
    end
  end
  always_ff @(posedge pclk) begin
    if (a_fire) begin
      h_op_reg <= ca_opcode;
      h_par_reg <= ca_param;
      h_sz_reg <= ca_size;
      h_src_reg <= ca_source;
      h_adr_reg <= ca_address;
      h_msk_reg <= ca_mask;
      h_dat_reg <= ca_data;
    end
  end

  // ****************************************
  // piece size selection
  // ****************************************
  wire [SW-1:0] mgr_lim = (max_reg < FLOOR_SZ) ? FLOOR_SZ :
                          (max_reg > CEIL_SZ) ? CEIL_SZ : max_reg;
  wire [SW-1:0] lim = ff_reg ? FLOOR_SZ : mgr_lim;
  wire h_arith = h_op_reg == tfs_pkg::OP_ARITH;
  wire h_big = h_sz_reg > lim;
  wire [SW-1:0] st_tsz = h_arith ? ((ff_reg && h_sz_reg > FLOOR_SZ) ? FLOOR_SZ : h_sz_reg) :
                         (h_big ? lim : h_sz_reg);
  wire [CW-1:0] st_pn = (!h_arith && h_big) ? (CW'(1) << (h_sz_reg - lim)) : CW'(1);
  wire [CW-1:0] st_bpp = h_arith ? beats(h_sz_reg) :
                         has_data(h_op_reg) ? beats(st_tsz) : CW'(1);
  wire st_dresp = (h_op_reg == tfs_pkg::OP_GET) || (h_op_reg == tfs_pkg::OP_LOGIC) ||
                  h_arith;
  wire [CW-1:0] st_resp = h_arith ? beats(st_tsz) : st_dresp ? beats(h_sz_reg) : st_pn;

  // ****************************************
  // request sequencer
  // ****************************************
  tfs_pkg::tfs_state_t st_reg;
  tfs_pkg::tfs_state_t st_next;
  logic [2:0] r_op_reg;
  logic [SW-1:0] r_sz_reg;
  logic [SW-1:0] r_tsz_reg;
  logic [SRC_W-1:0] r_src_reg;
  logic [ADDR_W-1:0] r_base_reg;
  logic [CW-1:0] r_pn_reg;
  logic [CW-1:0] r_bpp_reg;
  logic [CW-1:0] pi_reg;
  logic [CW-1:0] bi_reg;
  logic [CW-1:0] resp_reg;
  logic seen_reg;
  logic deny_reg;
  logic abuf_rdy;
  logic dbuf_rdy;
  assign busy = st_reg != tfs_pkg::ST_IDLE;
  wire start = (st_reg == tfs_pkg::ST_IDLE) & h_v_reg;
  wire emit = (st_reg == tfs_pkg::ST_RUN) & h_v_reg & abuf_rdy;
  wire last_piece = (pi_reg == r_pn_reg - CW'(1)) && (bi_reg == r_bpp_reg - CW'(1));
  wire md_fire = md_valid & dbuf_rdy;
  // data beats leave the holding stage one by one, reads and hints stay until the last piece
  assign h_take = emit & (has_data(r_op_reg) | last_piece);

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      tfs_pkg::ST_IDLE: begin
        if (h_v_reg) begin
          st_next = tfs_pkg::ST_RUN;
        end
      end
      tfs_pkg::ST_RUN: begin
        if (emit && last_piece) begin
          st_next = tfs_pkg::ST_DRAIN;
        end
      end
      tfs_pkg::ST_DRAIN: begin
        if (resp_reg == CW'(0)) begin
          st_next = tfs_pkg::ST_IDLE;
        end
      end
      default: st_next = tfs_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= tfs_pkg::ST_IDLE;
      r_op_reg <= 3'h0;
      r_sz_reg <= '0;
      r_tsz_reg <= '0;
      r_src_reg <= '0;
      r_base_reg <= '0;
      r_pn_reg <= '0;
      r_bpp_reg <= '0;
    end else begin
      st_reg <= st_next;
      if (start) begin
        r_op_reg <= h_op_reg;
        r_sz_reg <= h_sz_reg;
        r_tsz_reg <= st_tsz;
        r_src_reg <= h_src_reg;
        r_base_reg <= h_adr_reg;
        r_pn_reg <= st_pn;
        r_bpp_reg <= st_bpp;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pi_reg <= '0;
      bi_reg <= '0;
      pcnt_reg <= '0;
    end else if (start) begin
      pi_reg <= '0;
      bi_reg <= '0;
    end else if (emit) begin
      if (bi_reg == r_bpp_reg - CW'(1)) begin
        bi_reg <= '0;
        pi_reg <= pi_reg + CW'(1);
        pcnt_reg <= pcnt_reg + CW'(1);
      end else begin
        bi_reg <= bi_reg + CW'(1);
      end
    end
  end

  // the ceiling is what the client was promised; larger requests are flagged, not dropped
  wire over_set = start & (h_sz_reg > CEIL_SZ);
  wire over_clr = apb_wr & sel_stat & pwdata[tfs_pkg::STAT_OVER];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      over_reg <= 1'b0;
    end else if (over_set) begin
      over_reg <= 1'b1;
    end else if (over_clr) begin
      over_reg <= 1'b0;
    end
  end

  // ****************************************
  // manager a path
  // ****************************************
  wire [ADDR_W-1:0] piece_adr = r_base_reg + (ADDR_W'(pi_reg) << r_tsz_reg);
  wire [AW_PK-1:0] a_pk = {r_op_reg, h_par_reg, r_tsz_reg, r_src_reg, piece_adr,
                           h_msk_reg, h_dat_reg};
  wire [AW_PK-1:0] a_out;
  tfs_buf #(
    .W(AW_PK)
  ) u_abuf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(emit),
    .in_ready(abuf_rdy),
    .in_data(a_pk),
    .out_valid(ma_valid),
    .out_ready(ma_ready),
    .out_data(a_out)
  );
  assign {ma_opcode, ma_param, ma_size, ma_source, ma_address, ma_mask, ma_data} = a_out;

  // ****************************************
  // response merging
  // ****************************************
  wire r_full = r_op_reg == tfs_pkg::OP_PUTFULL;
  wire r_put = r_full | (r_op_reg == tfs_pkg::OP_PUTPART);
  wire r_dresp = (r_op_reg == tfs_pkg::OP_GET) || (r_op_reg == tfs_pkg::OP_LOGIC) ||
                 (r_op_reg == tfs_pkg::OP_ARITH);
  wire early = (ack_reg == tfs_pkg::ACK_ALL_FIRST) |
               ((ack_reg == tfs_pkg::ACK_FULL_FIRST) & r_full);
  wire resp_last = resp_reg == CW'(1);
  wire fwd = r_dresp | ((r_put & early) ? ~seen_reg : resp_last);
  wire first_den = seen_reg ? deny_reg : md_denied;
  wire d_den = r_dresp ? ((merge_reg && r_op_reg == tfs_pkg::OP_GET) ? first_den : md_denied) :
               (r_put & early) ? md_denied : (deny_reg | md_denied);
  wire [DW_PK-1:0] d_pk = {md_opcode, md_param, r_sz_reg, r_src_reg, d_den, md_corrupt,
                           md_data};
  wire [DW_PK-1:0] d_out;
  assign md_ready = dbuf_rdy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_reg <= '0;
      seen_reg <= 1'b0;
      deny_reg <= 1'b0;
    end else if (start) begin
      resp_reg <= st_resp;
      seen_reg <= 1'b0;
      deny_reg <= 1'b0;
    end else if (md_fire) begin
      resp_reg <= resp_reg - CW'(1);
      seen_reg <= 1'b1;
      deny_reg <= (r_dresp & merge_reg) ? first_den : (deny_reg | md_denied);
    end
  end

  tfs_buf #(
    .W(DW_PK)
  ) u_dbuf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(md_fire & fwd),
    .in_ready(dbuf_rdy),
    .in_data(d_pk),
    .out_valid(cd_valid),
    .out_ready(cd_ready),
    .out_data(d_out)
  );
  assign {cd_opcode, cd_param, cd_size, cd_source, cd_denied, cd_corrupt, cd_data} = d_out;
endmodule

// ==== rtl/tfs_pkg.sv ====
package tfs_pkg;
  // ****************************************
  // sizes and counters
  // ****************************************
  localparam int SIZE_W = 4;
  localparam int CNT_W = 16;
  localparam int FLOOR_DEF = 3;
  localparam int CEIL_DEF = 6;
  localparam int BEAT_LG_DEF = 3;
  // ****************************************
  // tilelink opcodes
  // ****************************************
  localparam logic [2:0] OP_PUTFULL = 3'h0;
  localparam logic [2:0] OP_PUTPART = 3'h1;
  localparam logic [2:0] OP_ARITH = 3'h2;
  localparam logic [2:0] OP_LOGIC = 3'h3;
  localparam logic [2:0] OP_GET = 3'h4;
  localparam logic [2:0] OP_HINT = 3'h5;
  // ****************************************
  // early acknowledge modes
  // ****************************************
  localparam logic [1:0] ACK_LAST = 2'h0;
  localparam logic [1:0] ACK_ALL_FIRST = 2'h1;
  localparam logic [1:0] ACK_FULL_FIRST = 2'h2;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_PCNT = 12'h008;
  localparam int CTRL_FF = 0;
  localparam int CTRL_ACK = 1;
  localparam int CTRL_MERGE = 3;
  localparam int CTRL_MAX = 4;
  localparam int STAT_BUSY = 0;
  localparam int STAT_OVER = 1;
  localparam logic [1:0] ACK_RST = 2'h0;
  localparam logic [3:0] MAX_RST = 4'h6;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DRAIN = 2'b11
  } tfs_state_t;
endpackage

// ==== rtl/tfs_buf.sv ====
`timescale 1ns/100ps
module tfs_buf #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic [W-1:0] d0_reg;
  logic [W-1:0] d1_reg;
  logic rdy_reg;
  logic vld_reg;
  wire push = in_valid & rdy_reg;
  wire pop = vld_reg & out_ready;
  // registered flags keep both handshakes free of combinational paths
  assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
  assign in_ready = rdy_reg;
  assign out_valid = vld_reg;
  assign out_data = d0_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 2'h0;
      rdy_reg <= 1'b0;
      vld_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      rdy_reg <= cnt_next != 2'h2;
      vld_reg <= cnt_next != 2'h0;
    end
  end
  always_ff @(posedge pclk) begin
    if (pop) begin
      if (cnt_reg == 2'h2) begin
        d0_reg <= d1_reg;
      end else if (push) begin
        d0_reg <= in_data;
      end
    end else if (push) begin
      if (cnt_reg == 2'h0) begin
        d0_reg <= in_data;
      end else begin
        d1_reg <= in_data;
      end
    end
  end
endmodule

// ==== sim/tfs_splitter_asserts.sv ====
`timescale 1ns/100ps
module tfs_splitter_asserts #(
  parameter int FLOOR_SIZE = 3,
  parameter int CEILING_SIZE = 6,
  parameter int ADDR_W = 32
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // tilelink handshakes
  input wire logic ca_valid,
  input wire logic ca_ready,
  input wire logic ma_valid,
  input wire logic ma_ready,
  input wire logic [tfs_pkg::SIZE_W-1:0] ma_size,
  input wire logic [ADDR_W-1:0] ma_address,
  input wire logic cd_valid,
  input wire logic cd_ready,
  input wire logic [tfs_pkg::SIZE_W-1:0] cd_size
);
  // ****
  // properties
  // ****
  wire [ADDR_W-1:0] ma_low = ma_address & ~({ADDR_W{1'b1}} << ma_size);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && !penable ##1 psel && penable && !pready;
  endsequence
  AST_APB_WAIT: assert property (s_access |=> pready)
    else $error("apb answer late");
  AST_APB_ERR: assert property (s_access ##0 paddr > 12'h008 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  AST_FLOOR: assert property (ma_valid |-> ma_size >= FLOOR_SIZE)
    else $error("piece below floor");
  AST_CEIL: assert property (cd_valid |-> cd_size <= CEILING_SIZE)
    else $error("response above ceiling");
  AST_ALIGN: assert property (ma_valid |-> ma_low == '0)
    else $error("piece not aligned to its size");
  AST_MA_HOLD: assert property (ma_valid && !ma_ready |=> ma_valid && $stable(ma_size))
    else $error("piece dropped before taken");
  AST_CD_HOLD: assert property (cd_valid && !cd_ready |=> cd_valid && $stable(cd_size))
    else $error("response dropped before taken");
  AST_ONE_REQ: assert property (ca_valid && ca_ready |=> !ca_ready)
    else $error("client beat taken twice");
  AST_ANSWER: assert property (!ma_valid && ca_valid && ca_ready |-> ##[1:4] ma_valid)
    else $error("no piece after client beat");
endmodule
bind tfs_splitter tfs_splitter_asserts #(
  .FLOOR_SIZE(FLOOR_SIZE), .CEILING_SIZE(CEILING_SIZE), .ADDR_W(ADDR_W)
) u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .ca_valid(ca_valid),
  .ca_ready(ca_ready), .ma_valid(ma_valid), .ma_ready(ma_ready), .ma_size(ma_size),
  .ma_address(ma_address), .cd_valid(cd_valid), .cd_ready(cd_ready), .cd_size(cd_size)
);

// ==== sim/tfs_mgr_model.sv ====
`timescale 1ns/100ps
module tfs_mgr_model #(
  parameter int BEAT_LG = 3
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // scenario controls
  input wire logic stall,
  input wire logic deny_en,
  // request side
  input wire logic ma_valid,
  output logic ma_ready,
  input wire logic [2:0] ma_opcode,
  input wire logic [tfs_pkg::SIZE_W-1:0] ma_size,
  input wire logic [31:0] ma_address,
  // response side
  output logic md_valid,
  input wire logic md_ready,
  output logic [2:0] md_opcode,
  output logic md_denied,
  output logic [63:0] md_data
);
  // ****
  // queued response beats
  // ****
  typedef struct packed {
    logic [2:0] op;
    logic dn;
    logic [31:0] ad;
  } tfs_beat_t;
  tfs_beat_t q[$];
  int bc;
  int nb;
  logic ph;
  logic wr;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.delete();
      bc = 0;
      ph <= 1'b0;
      ma_ready <= 1'b0;
      md_valid <= 1'b0;
      md_opcode <= 3'h0;
      md_denied <= 1'b0;
      md_data <= 64'h0;
    end else begin
      ph <= ~ph;
      // a slow manager takes and answers only every other cycle
      ma_ready <= ~stall | ph;
      if (md_valid && md_ready) begin
        void'(q.pop_front());
      end
      // only access and hint requests are served; no cached copy is held
      if (ma_valid && ma_ready) begin
        nb = (ma_size > BEAT_LG) ? 1 << (ma_size - BEAT_LG) : 1;
        wr = ma_opcode == tfs_pkg::OP_PUTFULL || ma_opcode == tfs_pkg::OP_PUTPART;
        bc = (ma_opcode >= tfs_pkg::OP_GET) ? nb : bc + 1;
        if (bc == nb) begin
          bc = 0;
          for (int i = 0; i < ((wr || ma_opcode == tfs_pkg::OP_HINT) ? 1 : nb); i++) begin
            q.push_back({wr ? 3'h0 : (ma_opcode == tfs_pkg::OP_HINT ? 3'h2 : 3'h1),
                         deny_en && ma_address[5:3] == 3'h0, ma_address + 32'(i * 8)});
          end
        end
      end
      if (!(md_valid && !md_ready)) begin
        if (q.size() != 0 && (!stall || ph)) begin
          md_valid <= 1'b1;
          md_opcode <= q[0].op;
          md_denied <= q[0].dn;
          md_data <= {~q[0].ad, q[0].ad};
        end else begin
          // released lines must not keep looking like the last beat
          md_valid <= 1'b0;
          md_opcode <= ~md_opcode;
          md_denied <= ~md_denied;
          md_data <= ~md_data;
        end
      end
    end
  end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
module testbench;
  // ****
  // signals
  // ****
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ca_ready, ma_valid, ma_ready, md_valid, md_ready, md_denied;
  logic ca_valid = 1'b0;
  logic [2:0] ca_opcode = 3'h0;
  logic [3:0] ca_size = 4'h0;
  logic [31:0] ca_address = 32'h0;
  logic [63:0] ca_data = 64'h0;
  logic [2:0] ma_opcode, md_opcode, cd_opcode;
  logic [2:0] exp_op = 3'h0;
  logic [2:0] exp_dop = 3'h0;
  logic [3:0] ma_size, cd_size, cd_source;
  logic [31:0] ma_address;
  logic [63:0] md_data, cd_data;
  logic cd_valid, cd_denied;
  logic cd_ready = 1'b0;
  logic stall = 1'b0;
  logic deny_en = 1'b0;
  logic chk_dat = 1'b0;
  logic [3:0] exp_msz = 4'h0;
  logic [3:0] exp_csz = 4'h0;
  logic [31:0] exp_base = 32'h0;
  int npc = 0;
  int nrs = 0;
  int ndn = 0;
  int pc_at_ack = 0;
  int mismatches = 0;
  int checked = 0;
  always #50 pclk = ~pclk;
  tfs_splitter dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ca_valid(ca_valid), .ca_ready(ca_ready), .ca_opcode(ca_opcode), .ca_param(3'h0),
    .ca_size(ca_size), .ca_source(4'h5), .ca_address(ca_address), .ca_mask(8'hff),
    .ca_data(ca_data), .ma_valid(ma_valid), .ma_ready(ma_ready), .ma_opcode(ma_opcode),
    .ma_param(), .ma_size(ma_size), .ma_source(), .ma_address(ma_address), .ma_mask(),
    .ma_data(), .md_valid(md_valid), .md_ready(md_ready), .md_opcode(md_opcode),
    .md_param(2'h0), .md_denied(md_denied), .md_corrupt(1'b0), .md_data(md_data),
    .cd_valid(cd_valid), .cd_ready(cd_ready), .cd_opcode(cd_opcode), .cd_size(cd_size),
    .cd_param(), .cd_source(cd_source), .cd_denied(cd_denied), .cd_corrupt(), .cd_data(cd_data)
  );
  tfs_mgr_model u_mgr (
    .pclk(pclk), .presetn(presetn), .stall(stall), .deny_en(deny_en), .ma_valid(ma_valid),
    .ma_ready(ma_ready), .ma_opcode(ma_opcode), .ma_size(ma_size), .ma_address(ma_address),
    .md_valid(md_valid), .md_ready(md_ready), .md_opcode(md_opcode), .md_denied(md_denied),
    .md_data(md_data)
  );
  // ****
  // shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask
  task automatic final_report;
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic set_ctrl(input logic ff, input logic [1:0] ak, input logic mg,
                          input logic [3:0] mx);
    logic [31:0] q;
    logic e;
    apb(1'b1, tfs_pkg::OFS_CTRL, {24'h0, mx, mg, ak, ff}, q, e);
  endtask
  // client beats go out one at a time; the client side never runs faster
  task automatic req(input logic [2:0] op, input logic [3:0] sz, input logic [31:0] ba,
                     input logic [3:0] msz, input int npx, input int nrx);
    int nb;
    int t;
    nb = (op < tfs_pkg::OP_GET && sz > 4'h3) ? 1 << (sz - 4'h3) : 1;
    exp_msz = msz;
    exp_csz = sz;
    exp_base = ba;
    exp_op = op;
    exp_dop = (op == tfs_pkg::OP_HINT) ? 3'h2 : (op < tfs_pkg::OP_ARITH) ? 3'h0 : 3'h1;
    chk_dat = op == tfs_pkg::OP_GET;
    npc <= 0;
    nrs <= 0;
    ndn <= 0;
    for (int i = 0; i < nb; i++) begin
      ca_valid <= 1'b1;
      ca_opcode <= op;
      ca_size <= sz;
      ca_address <= ba;
      ca_data <= {32'h0, ba + 32'(i * 8)};
      t = 0;
      do begin
        @(posedge pclk);
        t++;
      end while (ca_ready !== 1'b1 && t < 100);
      ca_valid <= 1'b0;
      @(posedge pclk);
    end
    t = 0;
    while (nrs < nrx && t < 1000) begin
      @(posedge pclk);
      t++;
    end
    repeat (20) @(posedge pclk);
    chk(32'(npc), 32'(npx), "piece count");
    chk(32'(nrs), 32'(nrx), "response count");
  endtask
  always @(posedge pclk) begin
    cd_ready <= !stall || !cd_ready;
    if (ma_valid && ma_ready) begin
      npc <= npc + 1;
      chk(32'({ma_opcode, ma_size}), 32'({exp_op, exp_msz}), "piece op or size");
    end
    if (cd_valid && cd_ready) begin
      nrs <= nrs + 1;
      ndn <= ndn + ((cd_denied === 1'b1) ? 1 : 0);
      if (nrs == 0) begin
        pc_at_ack <= npc;
      end
      chk({cd_opcode, cd_source, cd_size}, {exp_dop, 4'h5, exp_csz}, "response tag");
      if (chk_dat) begin
        chk(cd_data[31:0], exp_base + 32'(nrs * 8), "read data");
      end
    end
  end
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    apb(1'b0, tfs_pkg::OFS_CTRL, 32'h0, q, e);
    chk(q, 32'h0000_0060, "ctrl reset");
    apb(1'b0, tfs_pkg::OFS_STAT, 32'h0, q, e);
    chk(q, 32'h0, "stat reset");
    apb(1'b1, tfs_pkg::OFS_CTRL, 32'h0000_003f, q, e);
    apb(1'b1, 12'h010, 32'hffff_ffff, q, e);
    chk({31'h0, e}, 32'h1, "unmapped write");
    apb(1'b0, 12'h010, 32'h0, q, e);
    chk(q, 32'h0, "unmapped read");
    apb(1'b0, tfs_pkg::OFS_CTRL, 32'h0, q, e);
    chk(q, 32'h0000_003f, "ctrl readback");
  endtask
  task automatic t_get;
    logic [31:0] q;
    logic e;
    set_ctrl(1'b0, tfs_pkg::ACK_LAST, 1'b0, 4'h3);
    req(tfs_pkg::OP_GET, 4'h6, 32'h1000, 4'h3, 8, 8);
    apb(1'b0, tfs_pkg::OFS_PCNT, 32'h0, q, e);
    chk(q, 32'h8, "piece counter");
  endtask
  task automatic t_floor;
    set_ctrl(1'b1, tfs_pkg::ACK_LAST, 1'b0, 4'h6);
    req(tfs_pkg::OP_GET, 4'h5, 32'h2000, 4'h3, 4, 4);
    req(tfs_pkg::OP_ARITH, 4'h3, 32'h2000, 4'h3, 1, 1);
    set_ctrl(1'b0, tfs_pkg::ACK_LAST, 1'b0, 4'h6);
    req(tfs_pkg::OP_GET, 4'h5, 32'h2000, 4'h5, 1, 4);
    set_ctrl(1'b0, tfs_pkg::ACK_LAST, 1'b0, 4'h3);
    req(tfs_pkg::OP_ARITH, 4'h4, 32'h2000, 4'h4, 2, 2);
  endtask
  task automatic t_acks;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        set_ctrl(1'b0, 2'(m), 1'b0, 4'h3);
        req(k == 0 ? tfs_pkg::OP_PUTFULL : tfs_pkg::OP_PUTPART, 4'h6, 32'h3000, 4'h3, 8, 1);
        chk(32'(pc_at_ack < 8), 32'(m == 1 || (m == 2 && k == 0)), "ack moment");
      end
    end
  endtask
  task automatic t_merge;
    stall <= 1'b1;
    deny_en <= 1'b1;
    set_ctrl(1'b0, tfs_pkg::ACK_LAST, 1'b1, 4'h3);
    req(tfs_pkg::OP_GET, 4'h6, 32'h1000, 4'h3, 8, 8);
    chk(32'(ndn), 32'h8, "merged denial");
    set_ctrl(1'b0, tfs_pkg::ACK_LAST, 1'b0, 4'h3);
    req(tfs_pkg::OP_GET, 4'h6, 32'h1000, 4'h3, 8, 8);
    chk(32'(ndn), 32'h1, "unmerged denial");
    stall <= 1'b0;
    deny_en <= 1'b0;
  endtask
  task automatic t_hint;
    set_ctrl(1'b0, tfs_pkg::ACK_LAST, 1'b0, 4'h3);
    req(tfs_pkg::OP_HINT, 4'h6, 32'h2000, 4'h3, 8, 1);
    req(tfs_pkg::OP_LOGIC, 4'h5, 32'h2000, 4'h3, 4, 4);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_get();
    t_floor();
    t_acks();
    t_merge();
    t_hint();
    final_report();
  end
  // the scenarios need well under ten thousand cycles
  initial begin
    #4000000;
    mismatches++;
    final_report();
  end
endmodule
